// ==== hdl/exc_consts.svh ====
// named constants of the exception source and routing block
// assumes inclusion by bare name from the design files
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH

// ----------------------------------------------------------------
// register port and offsets
// ----------------------------------------------------------------
`define ADDR_W           8
`define OFF_RST_FLAGS    8'h00
`define OFF_NMI_FLAGS    8'h04
`define OFF_RESET_CTL    8'h08
`define OFF_TICK_CTRL    8'h10
`define OFF_TICK_RELOAD  8'h14
`define OFF_TICK_CURRENT 8'h18
`define OFF_TICK_CALIB   8'h1c
`define OFF_OSC_CTRL     8'h20
`define OFF_PORT_IE      8'h24
`define OFF_WAKE_EN      8'h28
`define OFF_WAKE_MODE_LO 8'h2c
`define OFF_WAKE_MODE_HI 8'h30
`define OFF_WAKE_CLEAR   8'h34
`define OFF_ROUTE_SEL    8'h38
`define OFF_SET_PEND     8'h3c
`define OFF_CLR_PEND     8'h40
`define OFF_IRQ_STATUS   8'h44

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RST_PIN          0
`define RST_POR          1
`define RST_VOLT         2
`define RST_FREQ         3
`define RST_WDOG         4
`define RST_SYSREQ       5
`define RST_N            6
`define SYSRESET_BIT     2
`define COUNTFLAG_BIT    16

// ----------------------------------------------------------------
// pins and interrupt slots
// ----------------------------------------------------------------
`define PIN_RST          0
`define PIN_EXT_A        1
`define PIN_EXT_B        2
`define PIN_EXT_C        3
`define PIN_OSC_A        4
`define PIN_OSC_B        5
`define NUM_PINS         6
`define PIN_IDLE         6'h01
`define NUM_IRQ          31
`define IRQ_NUM_W        5
`define SLOT_RSVD        4
`define SLOT_PIN_A       19
`define SLOT_PIN_B       20
`define SLOT_PIN_C       30
`define IRQ_VALID_MASK   31'h7fff_ffef

// ----------------------------------------------------------------
// tick timer
// ----------------------------------------------------------------
`define TICK_W           24
`define OSC_DIV          32
`define OSC_DIV_W        5
`define TICK_PERIOD_MS   10
`define MS_PER_S         1000

`endif

// ==== hdl/exc_pkg.sv ====
// types shared by the exception source and routing files
// assumes nothing beyond a SystemVerilog compiler
package exc_pkg;

	// same-clock reset event pulses from the supervisory units
	typedef struct packed {
		logic watchdog;
		logic freqDetect;
		logic voltDetect;
		logic powerOn;
	} reset_event_t;

	// tick timer control bits
	typedef struct packed {
		logic clkSrc;
		logic intEn;
		logic enable;
	} tick_ctrl_t;

	// active level or edge of a standby-release source
	typedef enum logic [1:0] {
		WAKE_LOW  = 2'h0,
		WAKE_HIGH = 2'h1,
		WAKE_FALL = 2'h2,
		WAKE_RISE = 2'h3
	} wake_mode_t;

endpackage : exc_pkg

// ==== hdl/tick_timer.sv ====
// down-counting system tick counter with reload
// assumes countPulse is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "exc_consts.svh"

module tick_timer #(
	parameter int W = `TICK_W
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// control
	input  wire logic         enable,
	input  wire logic         countPulse,
	input  wire logic [W-1:0] reloadValue,
	input  wire logic         clearCurrent,
	// state
	output var  logic [W-1:0] current,
	output var  logic         zeroEvent
);

	logic enPrev;

	// load on enable, then count down and flag the step to zero
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			current   <= '0;
			zeroEvent <= 1'b0;
			enPrev    <= 1'b0;
		end else begin
			enPrev    <= enable;
			zeroEvent <= 1'b0;
			if (clearCurrent) begin
				current <= '0;
			end else if (enable && !enPrev) begin
				current <= reloadValue;
			end else if (enable && countPulse) begin
				if (current == '0) begin
					current <= reloadValue;
				end else begin
					current <= current - W'(1);
					if (current == W'(1)) begin
						zeroEvent <= 1'b1;
					end
				end
			end
		end
	end

	a_tick_decrement: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		enable && enPrev && countPulse && !clearCurrent && current != '0
		|=> current == $past(current) - W'(1))
		else $error("tick counter did not decrement");

endmodule : tick_timer
`default_nettype wire

// ==== hdl/wake_detect.sv ====
// standby-release detector for one interrupt source
// assumes src is already on clk_sys
`timescale 1ns/1ps
`default_nettype none

module wake_detect (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// source and configuration
	input  wire logic              src,
	input  wire exc_pkg::wake_mode_t mode,
	input  wire logic              enable,
	input  wire logic              clear,
	// conditioned request
	output var  logic              request
);

	logic srcPrev;
	logic held;

	wire edgeHit  = (mode == exc_pkg::WAKE_RISE) ? (src && !srcPrev)
		: (!src && srcPrev);
	wire levelHit = (mode == exc_pkg::WAKE_HIGH) ? src : !src;

	// edge requests are held until cleared; a new edge beats the clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			srcPrev <= 1'b0;
			held    <= 1'b0;
		end else begin
			srcPrev <= src;
			if (enable && mode[1] && edgeHit) begin
				held <= 1'b1;
			end else if (clear) begin
				held <= 1'b0;
			end
		end
	end

	assign request = mode[1] ? held : (enable && levelHit);

	a_rise_held: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		enable && mode == exc_pkg::WAKE_RISE && src && !srcPrev
		&& $stable(mode) |=> request)
		else $error("rising edge not held as request");

endmodule : wake_detect
`default_nettype wire

// ==== hdl/exception_source_routing.sv ====
// reset and nmi cause capture, tick timer and interrupt routing
// assumes register strobes on clk_sys; pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "exc_consts.svh"

module exception_source_routing #(
	parameter int OSC_HZ = 10000000
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// register port
	input  wire logic [`ADDR_W-1:0]    regAddr,
	input  wire logic [31:0]           regWdata,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output var  logic [31:0]           regRdata,
	// reset and nmi sources
	input  wire logic                  resetPinIn,
	input  wire exc_pkg::reset_event_t resetEvents,
	input  wire logic                  watchdogNmi,
	// oscillator pins
	input  wire logic                  oscAIn,
	input  wire logic                  oscBIn,
	// interrupt sources
	input  wire logic [`NUM_IRQ-1:0]   periphIrq,
	input  wire logic                  extIrqPinA,
	input  wire logic                  extIrqPinB,
	input  wire logic                  extIrqPinC,
	// towards the cpu
	output var  logic [`NUM_IRQ-1:0]   cpuIrq,
	output var  logic                  irqActive,
	output var  logic [`IRQ_NUM_W-1:0] irqNumber,
	output var  logic                  nmiRequest,
	output var  logic                  resetRequest,
	output var  logic                  tickException
);

	localparam int CALIB_INT =
		(OSC_HZ / `OSC_DIV) * `TICK_PERIOD_MS / `MS_PER_S - 1;
	localparam logic [`TICK_W-1:0] CALIB = `TICK_W'(CALIB_INT);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------

	// slot fed by an external pin
	function automatic logic isPinSlot(input int n);
		isPinSlot = (n == `SLOT_PIN_A) || (n == `SLOT_PIN_B)
			|| (n == `SLOT_PIN_C);
	endfunction : isPinSlot

	// lowest numbered set bit, valid flag on top
	function automatic logic [`IRQ_NUM_W:0] lowestSet(
		input logic [`NUM_IRQ-1:0] v);
		logic [`IRQ_NUM_W:0] r;
		r = '0;
		for (int i = `NUM_IRQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, i[`IRQ_NUM_W-1:0]};
			end
		end
		lowestSet = r;
	endfunction : lowestSet

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------

	logic [`NUM_PINS-1:0] pinSync1;
	logic [`NUM_PINS-1:0] pinSync2;
	wire  [`NUM_PINS-1:0] pinRaw = {oscBIn, oscAIn, extIrqPinC,
		extIrqPinB, extIrqPinA, resetPinIn};

	// two flops before any logic looks at a pin; reset to idle levels
	// so the high-idling reset pin shows no false edge after reset
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			pinSync1 <= `PIN_IDLE;
			pinSync2 <= `PIN_IDLE;
		end else begin
			pinSync1 <= pinRaw;
			pinSync2 <= pinSync1;
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------

	function automatic logic hit(input logic s,
		input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
		hit = s && (a == off);
	endfunction : hit

	wire wrRstFlags = hit(regWrite, regAddr, `OFF_RST_FLAGS);
	wire wrNmiFlags = hit(regWrite, regAddr, `OFF_NMI_FLAGS);
	wire wrResetCtl = hit(regWrite, regAddr, `OFF_RESET_CTL);
	wire wrTickCtrl = hit(regWrite, regAddr, `OFF_TICK_CTRL);
	wire wrReload   = hit(regWrite, regAddr, `OFF_TICK_RELOAD);
	wire wrCurrent  = hit(regWrite, regAddr, `OFF_TICK_CURRENT);
	wire wrOscCtrl  = hit(regWrite, regAddr, `OFF_OSC_CTRL);
	wire wrPortIe   = hit(regWrite, regAddr, `OFF_PORT_IE);
	wire wrWakeEn   = hit(regWrite, regAddr, `OFF_WAKE_EN);
	wire wrModeLo   = hit(regWrite, regAddr, `OFF_WAKE_MODE_LO);
	wire wrModeHi   = hit(regWrite, regAddr, `OFF_WAKE_MODE_HI);
	wire wrWakeClr  = hit(regWrite, regAddr, `OFF_WAKE_CLEAR);
	wire wrRoute    = hit(regWrite, regAddr, `OFF_ROUTE_SEL);
	wire wrSetPend  = hit(regWrite, regAddr, `OFF_SET_PEND);
	wire wrClrPend  = hit(regWrite, regAddr, `OFF_CLR_PEND);
	wire rdTickCtrl = hit(regRead, regAddr, `OFF_TICK_CTRL);

	// ----------------------------------------------------------------
	// reset and nmi causes
	// ----------------------------------------------------------------

	logic                  rstPinPrev;
	logic [`RST_N-1:0]     rstFlags;
	logic                  nmiFlag;

	wire sysReq = wrResetCtl && regWdata[`SYSRESET_BIT];
	wire rstPinRise = pinSync2[`PIN_RST] && !rstPinPrev;
	// supervisory sources join the pin and request
	wire [`RST_N-1:0] rstEvent = {sysReq, resetEvents.watchdog,
		resetEvents.freqDetect, resetEvents.voltDetect,
		resetEvents.powerOn, rstPinRise};

	// latest cause replaces the flags, and beats a clear
	wire [`RST_N-1:0] next_rstFlags = (|rstEvent) ? rstEvent
		: wrRstFlags ? (rstFlags & ~regWdata[`RST_N-1:0]) : rstFlags;
	// watchdog nmi cause, set beats clear
	wire next_nmiFlag = watchdogNmi || (nmiFlag && !(wrNmiFlags
		&& regWdata[0]));

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rstPinPrev   <= 1'b1;
			rstFlags     <= '0;
			nmiFlag      <= 1'b0;
			resetRequest <= 1'b0;
			nmiRequest   <= 1'b0;
		end else begin
			rstPinPrev   <= pinSync2[`PIN_RST];
			rstFlags     <= next_rstFlags;
			nmiFlag      <= next_nmiFlag;
			resetRequest <= |rstEvent;
			nmiRequest   <= watchdogNmi;
		end
	end

	// ----------------------------------------------------------------
	// tick timer and its reference clock
	// ----------------------------------------------------------------

	exc_pkg::tick_ctrl_t   tickCtrl;
	logic [`TICK_W-1:0]    tickReload;
	logic [`TICK_W-1:0]    tickCurrent;
	logic                  tickZero;
	logic                  countFlag;
	logic                  oscillator_select_field;
	logic                  oscPrev;
	logic [`OSC_DIV_W-1:0] divCnt;

	wire oscNow  = oscillator_select_field ? pinSync2[`PIN_OSC_B] : pinSync2[`PIN_OSC_A];
	wire oscEdge = oscNow && !oscPrev;
	wire refTick = oscEdge && (divCnt == `OSC_DIV_W'(`OSC_DIV - 1));
	wire countPulse = tickCtrl.clkSrc ? 1'b1 : refTick;

	// pollable flag, set beats the read clear
	wire next_countFlag = tickZero || (countFlag && !rdTickCtrl);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tickCtrl      <= '0;
			tickReload    <= '0;
			countFlag     <= 1'b0;
			oscillator_select_field        <= 1'b0;
			oscPrev       <= 1'b0;
			divCnt        <= '0;
			tickException <= 1'b0;
		end else begin
			if (wrTickCtrl) tickCtrl <= regWdata[2:0];
			if (wrReload) tickReload <= regWdata[`TICK_W-1:0];
			if (wrOscCtrl) oscillator_select_field <= regWdata[0];
			oscPrev       <= oscNow;
			if (oscEdge) divCnt <= divCnt + `OSC_DIV_W'(1);
			countFlag     <= next_countFlag;
			tickException <= tickZero && tickCtrl.intEn;
		end
	end

	tick_timer #(
		.W(`TICK_W)
	) u_tick (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.enable      (tickCtrl.enable),
		.countPulse  (countPulse),
		.reloadValue (tickReload),
		.clearCurrent(wrCurrent),
		.current     (tickCurrent),
		.zeroEvent   (tickZero)
	);

	// ----------------------------------------------------------------
	// interrupt sources and routing
	// ----------------------------------------------------------------

	logic [2:0]            portIe;
	logic [`NUM_IRQ-1:0]   wakeEn;
	logic [2*`NUM_IRQ-1:0] wakeMode;
	logic [`NUM_IRQ-1:0]   routeSel;
	logic [`NUM_IRQ-1:0]   pend;
	logic [`NUM_IRQ-1:0]   srcVec;
	logic [`NUM_IRQ-1:0]   wakeReq;
	logic [`NUM_IRQ-1:0]   routed;

	// disabled pin input reads as high
	wire pinA = portIe[0] ? pinSync2[`PIN_EXT_A] : 1'b1;
	wire pinB = portIe[1] ? pinSync2[`PIN_EXT_B] : 1'b1;
	wire pinC = portIe[2] ? pinSync2[`PIN_EXT_C] : 1'b1;
	wire [`NUM_IRQ-1:0] wakeClr = wrWakeClr ? regWdata[`NUM_IRQ-1:0]
		: '0;

	genvar gi;
	for (gi = 0; gi < `NUM_IRQ; gi++) begin : g_slot
		localparam bit IS_PIN = isPinSlot(gi);
		wire [1:0] rawMode = wakeMode[2*gi +: 2];
		// peripheral sources may only use edges
		wire [1:0] useMode = IS_PIN ? rawMode : {1'b1, rawMode[0]};

		assign srcVec[gi] = (gi == `SLOT_PIN_A) ? pinA
			: (gi == `SLOT_PIN_B) ? pinB
			: (gi == `SLOT_PIN_C) ? pinC : periphIrq[gi];

		// standby sources pass the release logic
		wake_detect u_wake (
			.clk_sys(clk_sys),
			.resetn (resetn),
			.src    (srcVec[gi]),
			.mode   (exc_pkg::wake_mode_t'(useMode)),
			.enable (wakeEn[gi]),
			.clear  (wakeClr[gi]),
			.request(wakeReq[gi])
		);

		assign routed[gi] = routeSel[gi] ? wakeReq[gi] : srcVec[gi];
	end

	// software pending bits, set beats clear
	wire [`NUM_IRQ-1:0] setBits = wrSetPend ? regWdata[`NUM_IRQ-1:0]
		: '0;
	wire [`NUM_IRQ-1:0] next_pend = (setBits | (pend & ~(wrClrPend
		? regWdata[`NUM_IRQ-1:0] : '0))) & `IRQ_VALID_MASK;
	wire [`NUM_IRQ-1:0] next_cpuIrq = (routed | pend) & `IRQ_VALID_MASK;
	wire [`IRQ_NUM_W:0] next_top = lowestSet(next_cpuIrq);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			portIe    <= '0;
			wakeEn    <= '0;
			wakeMode  <= '0;
			routeSel  <= '0;
			pend      <= '0;
			cpuIrq    <= '0;
			irqActive <= 1'b0;
			irqNumber <= '0;
		end else begin
			if (wrPortIe) portIe <= regWdata[2:0];
			if (wrWakeEn) wakeEn <= regWdata[`NUM_IRQ-1:0];
			if (wrModeLo) wakeMode[31:0] <= regWdata;
			if (wrModeHi) wakeMode[2*`NUM_IRQ-1:32] <= regWdata[29:0];
			if (wrRoute) routeSel <= regWdata[`NUM_IRQ-1:0];
			pend      <= next_pend;
			cpuIrq    <= next_cpuIrq;
			irqActive <= next_top[`IRQ_NUM_W];
			irqNumber <= next_top[`IRQ_NUM_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------

	wire [31:0] readMux =
		(regAddr == `OFF_RST_FLAGS)    ? {26'h0, rstFlags}
		: (regAddr == `OFF_NMI_FLAGS)    ? {31'h0, nmiFlag}
		: (regAddr == `OFF_TICK_CTRL)    ? {15'h0, countFlag, 13'h0,
			tickCtrl}
		: (regAddr == `OFF_TICK_RELOAD)  ? {8'h0, tickReload}
		: (regAddr == `OFF_TICK_CURRENT) ? {8'h0, tickCurrent}
		: (regAddr == `OFF_TICK_CALIB)   ? {8'h0, CALIB}
		: (regAddr == `OFF_OSC_CTRL)     ? {31'h0, oscillator_select_field}
		: (regAddr == `OFF_PORT_IE)      ? {29'h0, portIe}
		: (regAddr == `OFF_WAKE_EN)      ? {1'h0, wakeEn}
		: (regAddr == `OFF_WAKE_MODE_LO) ? wakeMode[31:0]
		: (regAddr == `OFF_WAKE_MODE_HI) ? {2'h0,
			wakeMode[2*`NUM_IRQ-1:32]}
		: (regAddr == `OFF_ROUTE_SEL)    ? {1'h0, routeSel}
		: (regAddr == `OFF_SET_PEND)     ? {1'h0, pend}
		: (regAddr == `OFF_IRQ_STATUS)   ? {1'h0, cpuIrq}
		: 32'h0;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			regRdata <= '0;
		end else begin
			regRdata <= regRead ? readMux : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	a_por_cause: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		resetEvents.powerOn |=> rstFlags[`RST_POR] && resetRequest)
		else $error("power-on cause not recorded");

	a_pin_reset: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		pinSync2[`PIN_RST] && !rstPinPrev
		|=> rstFlags[`RST_PIN] && resetRequest)
		else $error("reset pin edge not taken");

	a_sysreq_cause: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		wrResetCtl && regWdata[`SYSRESET_BIT]
		|=> rstFlags == 6'h20 && resetRequest)
		else $error("system reset request not taken");

	a_latest_cause: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		|rstEvent |=> rstFlags == $past(rstEvent))
		else $error("reset cause flags not the latest");

	a_nmi_cause: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		watchdogNmi |=> nmiRequest && nmiFlag)
		else $error("watchdog nmi not recorded");

	a_tick_exception: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		tickZero |=> countFlag && (tickException == $past(tickCtrl.intEn)))
		else $error("tick zero not signalled");

	a_calib_read: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		regRead && regAddr == `OFF_TICK_CALIB
		|=> regRdata == {8'h0, CALIB})
		else $error("calibration value wrong");

	a_pin_disabled: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		!portIe[0] && !routeSel[`SLOT_PIN_A] |=> cpuIrq[`SLOT_PIN_A])
		else $error("disabled pin did not read high");

	a_direct_route: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		!routeSel[8] && !pend[8] |=> cpuIrq[8] == $past(periphIrq[8]))
		else $error("direct route not followed");

	a_set_pending: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		wrSetPend && regWdata[0] && !wrClrPend |=> ##1 cpuIrq[0])
		else $error("set-pending did not request");

	a_reserved_slot: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		!cpuIrq[`SLOT_RSVD])
		else $error("reserved slot requested");

	a_priority_top: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		irqActive |-> cpuIrq[irqNumber]
		&& ((cpuIrq & ~({`NUM_IRQ{1'b1}} << irqNumber)) == '0))
		else $error("served request is not the lowest number");

endmodule : exception_source_routing
`default_nettype wire

// ==== verification/irq_source_model.sv ====
// partner model: peripheral sources, irq pins and supervisory units
// assumes clk_sys from the bench; changes only after rising edges
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
	// clock
	input  wire logic                  clk_sys,
	// request sources
	output var  logic [30:0]           periphIrq,
	output var  logic                  extIrqPinA,
	output var  logic                  extIrqPinB,
	output var  logic                  extIrqPinC,
	// supervisory sources
	output var  logic                  resetPinIn,
	output var  exc_pkg::reset_event_t resetEvents,
	output var  logic                  watchdogNmi,
	// oscillators
	output var  logic                  oscAIn,
	output var  logic                  oscBIn
);
	// idle levels; pins held low before their input is enabled
	// irq pins held low, reset pin held high
	initial begin
		{periphIrq, extIrqPinA, extIrqPinB, extIrqPinC} = '0;
		resetPinIn = 1'b1;
		resetEvents = '0;
		{watchdogNmi, oscAIn, oscBIn} = '0;
	end

	// free-running oscillators, unrelated to any frame
	always @(posedge clk_sys) begin
		oscAIn <= ~oscAIn;
		oscBIn <= oscAIn;
	end

	task setPeriph(input logic [30:0] v);
		@(posedge clk_sys);
		periphIrq <= v;
	endtask : setPeriph

	// one supervisory event: 0 pin, 1 por, 2 volt, 3 freq, 4 wdog, 6 nmi
	task fire(input int k);
		@(posedge clk_sys);
		case (k)
			0: resetPinIn <= 1'b0;
			1: resetEvents.powerOn <= 1'b1;
			2: resetEvents.voltDetect <= 1'b1;
			3: resetEvents.freqDetect <= 1'b1;
			4: resetEvents.watchdog <= 1'b1;
			default: watchdogNmi <= 1'b1;
		endcase
		repeat (k == 0 ? 4 : 1) @(posedge clk_sys);
		resetPinIn <= 1'b1;
		resetEvents <= '0;
		watchdogNmi <= 1'b0;
	endtask : fire
endmodule : irq_source_model
`default_nettype wire

// ==== verification/exception_source_routing_tb.sv ====
// self-checking bench of the exception source and routing block
// assumes the design files and irq_source_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "exc_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
`define WAITF(c) #1 for (n = 0; n < 20 && !(c); n++) begin @(posedge clk_sys); #1; end

module exception_source_routing_tb;
	localparam int OSC = 6400000;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdata, d;
	logic [30:0] periphIrq, cpuIrq, v, e;
	logic extIrqPinA, extIrqPinB, extIrqPinC, resetPinIn, watchdogNmi;
	logic oscAIn, oscBIn, irqActive, nmiRequest, resetRequest, tickException;
	logic [4:0] irqNumber;
	exc_pkg::reset_event_t resetEvents;
	int mismatches, check_count, n, c, lo, cyc;

	// ----------------------------------------------------------------
	// clock, design and partner
	// ----------------------------------------------------------------
	always #2.5 clk_sys = ~clk_sys;

	exception_source_routing #(.OSC_HZ(OSC)) exception_source_routing_inst (.*);
	irq_source_model irq_source_model_inst (.*);

	// register bus cycles
	task wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk_sys);
		{regAddr, regWdata, regWrite} <= {a, w, 1'b1};
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : rd

	task end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(38));
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		// disabled pins present high and reach the cpu directly
		repeat (6) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h4018_0000)
		`CHK(irqNumber, 5'd19)
		wr(`OFF_PORT_IE, 32'h7);
		repeat (5) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h0)
		$display("pin test done");
		// direct sources used without wake setup
		for (int i = 0; i < 6; i++) begin
			v = 31'($urandom) & `IRQ_VALID_MASK;
			irq_source_model_inst.setPeriph(v);
			repeat (2) @(posedge clk_sys);
			#1 e = v & 31'h3fe7_ffff;
			lo = 0;
			while (lo < 30 && !e[lo]) lo++;
			`CHK(cpuIrq, e)
			`CHK(irqActive, |e)
			if (e != 0) `CHK(irqNumber, lo[4:0])
		end
		irq_source_model_inst.setPeriph('0);
		wr(`OFF_SET_PEND, 32'h80);
		repeat (3) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h80)
		wr(`OFF_CLR_PEND, 32'h80);
		repeat (3) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h0)
		// slot 8 through the release logic on a rising edge
		wr(`OFF_WAKE_MODE_LO, 32'h3_0000);
		wr(`OFF_WAKE_EN, 32'h100);
		wr(`OFF_ROUTE_SEL, 32'h100);
		irq_source_model_inst.setPeriph(31'h100);
		repeat (3) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h100)
		irq_source_model_inst.setPeriph('0);
		repeat (3) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h100)
		wr(`OFF_WAKE_CLEAR, 32'h100);
		repeat (3) @(posedge clk_sys);
		#1 `CHK(cpuIrq, 31'h0)
		wr(`OFF_ROUTE_SEL, 32'h0);
		$display("routing test done");
		// each reset source replaces the cause flags
		for (int k = 0; k < 6; k++) begin
			if (k == 5) wr(`OFF_RESET_CTL, 32'h4);
			else irq_source_model_inst.fire(k);
			`WAITF(resetRequest === 1'b1)
			`CHK(resetRequest, 1'b1)
			rd(`OFF_RST_FLAGS);
			`CHK(d, 32'h1 << k)
		end
		irq_source_model_inst.fire(6);
		`WAITF(nmiRequest === 1'b1)
		`CHK(nmiRequest, 1'b1)
		rd(`OFF_NMI_FLAGS);
		`CHK(d, 32'h1)
		$display("reset test done");
		// tick timer on clk_sys, reload 3 gives four cycles a period
		wr(`OFF_TICK_CALIB, 32'hffff_ffff);
		rd(`OFF_TICK_CALIB);
		`CHK(d, 32'((OSC / `OSC_DIV) * `TICK_PERIOD_MS / `MS_PER_S - 1))
		rd(8'hfc);
		`CHK(d, 32'h0)
		wr(`OFF_TICK_RELOAD, 32'h3);
		wr(`OFF_TICK_CTRL, 32'h7);
		`WAITF(tickException === 1'b1)
		c = 0;
		do begin
			@(posedge clk_sys);
			#1 c++;
		end while (tickException !== 1'b1 && c < 20);
		`CHK(c, 4)
		rd(`OFF_TICK_CTRL);
		`CHK(d, 32'h1_0007)
		wr(`OFF_TICK_CTRL, 32'h0);
		$display("tick test done");
		end_sim();
	end
endmodule : exception_source_routing_tb
`default_nettype wire
